// >>> pkg/adc_conv_params.svh
// Timing and width constants for the conversion and readout block
`ifndef ADC_CONV_PARAMS_SVH
`define ADC_CONV_PARAMS_SVH

// Clock rate and rounding helpers
`define CLK_PERIOD_NS      40
`define CEIL_CYC(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOOR_CYC(ns)      ((ns) / `CLK_PERIOD_NS)

// Result and counter widths
`define RESULT_BITS        18
`define CNT_W              6
`define HALF_W             3
`define GAP_W              2
`define BIT_W              5
`define BUSY_LEN_W         8

// Conversion sequencing times
`define CONV_NS            1440
`define RDC_SYNC_NS        530
`define RAC_SYNC_NS        1500
`define BUSY_MAX_NS        1680
`define SYNC_LEAD_NS       20

// Serial clock high phase minimum per divider setting
`define DIV0_HIGH_NS       15
`define DIV1_HIGH_NS       30
`define DIV2_HIGH_NS       60
`define DIV3_HIGH_NS       120

// Last serial clock edge to frame change minimum per divider setting
`define DIV0_TAIL_NS       5
`define DIV1_TAIL_NS       7
`define DIV2_TAIL_NS       35
`define DIV3_TAIL_NS       90

// Busy high maximum in read-after-convert per divider setting
`define DIV0_BUSY_NS       2550
`define DIV1_BUSY_NS       3400
`define DIV2_BUSY_NS       5000
`define DIV3_BUSY_NS       8200

`endif

// >>> pkg/adc_conv_pkg.sv
// Types and the serial clock decode function for the conversion and readout block
package adc_conv_pkg;
`include "adc_conv_params.svh"

   // Readout mode selection
   typedef enum logic [1:0] {
      MODE_PARALLEL,
      MODE_MASTER_RDC,
      MODE_MASTER_RAC,
      MODE_SLAVE
   } readout_mode_type;

   // Serial readout phases
   typedef enum logic [2:0] {
      SER_IDLE,
      SER_LEAD,
      SER_SHIFT,
      SER_TAIL,
      SER_END
   } ser_phase_type;

   // Serial pins: value and output enable of each
   typedef struct packed {
      logic frame;
      logic frame_oe;
      logic clk;
      logic clk_oe;
      logic data;
      logic data_oe;
   } serial_pins_type;

   // Serial clock half period in cycles per divider setting
   function automatic logic [`HALF_W-1:0] half_cycles(input logic [1:0] div);
      case (div)
         2'h0:    half_cycles = `HALF_W'(`CEIL_CYC(`DIV0_HIGH_NS));
         2'h1:    half_cycles = `HALF_W'(`CEIL_CYC(`DIV1_HIGH_NS));
         2'h2:    half_cycles = `HALF_W'(`CEIL_CYC(`DIV2_HIGH_NS));
         default: half_cycles = `HALF_W'(`CEIL_CYC(`DIV3_HIGH_NS));
      endcase
   endfunction : half_cycles

endpackage : adc_conv_pkg

// >>> hdl/serial_clock_gen.sv
// Internal serial clock generator with edge pulses
`timescale 1ns/1ps
`include "adc_conv_params.svh"
module serial_clock_gen
   import adc_conv_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                run,
   input  wire logic [`HALF_W-1:0]  half,
   output logic                     sclk,
   output logic                     rise_next,
   output logic                     fall_next
);

   typedef struct packed {
      logic [`HALF_W-1:0] cnt;
      logic               sclk;
   } gen_state_type;

   gen_state_type gen_reg;
   gen_state_type gen_next;

   // Half period count, toggle at its end; idle low
   always_comb
   begin
      gen_next  = gen_reg;
      rise_next = 1'b0;
      fall_next = 1'b0;
      if (!run)
      begin
         gen_next = '0;
      end
      else if (gen_reg.cnt + `HALF_W'(1) >= half)
      begin
         gen_next.cnt  = '0;
         gen_next.sclk = ~gen_reg.sclk;
         rise_next     = ~gen_reg.sclk;
         fall_next     = gen_reg.sclk;
      end
      else
      begin
         gen_next.cnt = gen_reg.cnt + `HALF_W'(1);
      end
   end

   // State register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         gen_reg <= '0;
      else
         gen_reg <= gen_next;
   end

   assign sclk = gen_reg.sclk;

endmodule : serial_clock_gen

// >>> hdl/adc_conversion_readout_timing.sv
// Conversion sequencing and result readout: parallel, master serial, slave serial
`timescale 1ns/1ps
`include "adc_conv_params.svh"
module adc_conversion_readout_timing
   import adc_conv_pkg::*;
#(
   parameter int RESULT_BITS = `RESULT_BITS
)
(
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   convert_start_n,
   input  wire readout_mode_type       mode,
   input  wire logic [1:0]             serial_clock_divider,
   input  wire logic                   cs_n,
   input  wire logic                   rd_n,
   input  wire logic                   serial_data_clock_in,
   input  wire logic [RESULT_BITS-1:0] conv_result_in,
   output logic                        busy,
   output logic [RESULT_BITS-1:0]      data_out,
   output logic                        data_oe,
   output serial_pins_type             serial_pins
);

   // Sequencing points in cycles after the strobe edge
   localparam logic [`CNT_W-1:0]  CONV_AT     = `CNT_W'(`FLOOR_CYC(`CONV_NS));
   localparam logic [`CNT_W-1:0]  BUSY_END_AT = `CNT_W'(`FLOOR_CYC(`CONV_NS) + 1);
   localparam logic [`CNT_W-1:0]  RDC_SYNC_AT = `CNT_W'(`FLOOR_CYC(`RDC_SYNC_NS));
   localparam logic [`CNT_W-1:0]  RAC_SYNC_AT = `CNT_W'(`FLOOR_CYC(`RAC_SYNC_NS));
   localparam logic [`CNT_W-1:0]  CNT_MAX     = '1;
   localparam logic [`BIT_W-1:0]  LAST_BIT    = `BIT_W'(RESULT_BITS - 1);
   localparam logic [`BUSY_LEN_W-1:0] BUSY_MAX_CYC = `BUSY_LEN_W'(`FLOOR_CYC(`BUSY_MAX_NS));

   typedef struct packed {
      logic                   strobe_prev;
      logic                   ext_prev;
      logic                   busy;
      logic [`CNT_W-1:0]      cnt;
      logic [RESULT_BITS-1:0] result;
      logic [RESULT_BITS-1:0] shift;
      ser_phase_type          ser;
      logic [`BIT_W-1:0]      bit_cnt;
      logic [`GAP_W-1:0]      gap;
      logic                   frame;
   } ctrl_state_type;

   ctrl_state_type ctrl_reg;
   ctrl_state_type ctrl_next;

   logic                   strobe_fall;
   logic                   master;
   logic                   run;
   logic                   sclk;
   logic                   sclk_rise_next;
   logic                   sclk_fall_next;
   logic [`HALF_W-1:0]     half;

   // Frame tail wait after the last serial clock edge
   function automatic logic [`GAP_W-1:0] tail_cycles(input logic [1:0] div);
      case (div)
         2'h0:    tail_cycles = `GAP_W'(`CEIL_CYC(`DIV0_TAIL_NS));
         2'h1:    tail_cycles = `GAP_W'(`CEIL_CYC(`DIV1_TAIL_NS));
         2'h2:    tail_cycles = `GAP_W'(`CEIL_CYC(`DIV2_TAIL_NS));
         default: tail_cycles = `GAP_W'(`CEIL_CYC(`DIV3_TAIL_NS));
      endcase
   endfunction : tail_cycles

   // Mode decode and serial clock setting
   assign strobe_fall = ctrl_reg.strobe_prev & ~convert_start_n;
   assign master      = (mode == MODE_MASTER_RDC) || (mode == MODE_MASTER_RAC);
   assign run         = (ctrl_reg.ser == SER_SHIFT);
   assign half        = (mode == MODE_MASTER_RDC) ? half_cycles(2'h0)
                                                  : half_cycles(serial_clock_divider);

   // Internal serial clock
   serial_clock_gen u_sclk (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .run       (run),
      .half      (half),
      .sclk      (sclk),
      .rise_next (sclk_rise_next),
      .fall_next (sclk_fall_next)
   );

   // Next-state logic: conversion sequencing and serial readout
   always_comb
   begin
      ctrl_next             = ctrl_reg;
      ctrl_next.strobe_prev = convert_start_n;
      ctrl_next.ext_prev    = serial_data_clock_in;

      // Start of conversion; strobes during busy or master serial readout are ignored
      if (strobe_fall && !ctrl_reg.busy && ctrl_reg.ser == SER_IDLE)
      begin
         ctrl_next.busy = 1'b1;
         ctrl_next.cnt  = `CNT_W'(1);
      end
      else if (ctrl_reg.cnt != '0 && ctrl_reg.cnt != CNT_MAX)
      begin
         ctrl_next.cnt = ctrl_reg.cnt + `CNT_W'(1);
      end

      // Conversion complete: capture result
      if (ctrl_reg.cnt == CONV_AT)
      begin
         ctrl_next.result = conv_result_in;
         if (mode != MODE_MASTER_RDC)
            ctrl_next.shift = conv_result_in;
      end

      // Busy falls one cycle after capture, except read-after-convert
      if (ctrl_reg.cnt == BUSY_END_AT && mode != MODE_MASTER_RAC)
         ctrl_next.busy = 1'b0;

      // Slave serial: advance on external clock rising edge
      if (mode == MODE_SLAVE && !cs_n && serial_data_clock_in && !ctrl_reg.ext_prev)
         ctrl_next.shift = {ctrl_reg.shift[RESULT_BITS-2:0], 1'b0};

      // Master serial readout sequence
      case (ctrl_reg.ser)
         SER_IDLE:
         begin
            if ((mode == MODE_MASTER_RDC && ctrl_reg.cnt == RDC_SYNC_AT) ||
                (mode == MODE_MASTER_RAC && ctrl_reg.cnt == RAC_SYNC_AT))
            begin
               ctrl_next.ser     = SER_LEAD;
               ctrl_next.frame   = 1'b1;
               ctrl_next.bit_cnt = '0;
               if (mode == MODE_MASTER_RDC)
                  ctrl_next.shift = ctrl_reg.result;   // Previous result
            end
         end
         SER_LEAD:
         begin
            ctrl_next.ser = SER_SHIFT;                 // One cycle before first edge
         end
         SER_SHIFT:
         begin
            if (sclk_fall_next)                        // Data moves with falling edge
            begin
               ctrl_next.shift   = {ctrl_reg.shift[RESULT_BITS-2:0], 1'b0};
               ctrl_next.bit_cnt = ctrl_reg.bit_cnt + `BIT_W'(1);
               if (ctrl_reg.bit_cnt == LAST_BIT)
               begin
                  ctrl_next.ser = SER_TAIL;
                  ctrl_next.gap = tail_cycles(serial_clock_divider);
               end
            end
         end
         SER_TAIL:
         begin
            ctrl_next.gap = ctrl_reg.gap - `GAP_W'(1);
            if (ctrl_reg.gap <= `GAP_W'(1))
            begin
               ctrl_next.frame = 1'b0;
               ctrl_next.ser   = SER_END;
            end
         end
         SER_END:
         begin
            if (mode == MODE_MASTER_RAC)
               ctrl_next.busy = 1'b0;                  // One cycle after frame
            ctrl_next.ser = SER_IDLE;
         end
         default:
         begin
            ctrl_next.ser = SER_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ctrl_reg             <= '0;
         ctrl_reg.strobe_prev <= 1'b1;
         ctrl_reg.ser         <= SER_IDLE;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Parallel bus and busy outputs
   assign busy     = ctrl_reg.busy;
   assign data_out = ctrl_reg.result;
   assign data_oe  = (mode == MODE_PARALLEL) && !cs_n && !rd_n;

   // Serial pins, driven only while selected
   always_comb
   begin
      serial_pins.frame    = ctrl_reg.frame;
      serial_pins.clk      = sclk;
      serial_pins.data     = ctrl_reg.shift[RESULT_BITS-1];
      serial_pins.frame_oe = master && !cs_n;
      serial_pins.clk_oe   = master && !cs_n;
      serial_pins.data_oe  = (master || mode == MODE_SLAVE) && !cs_n;
   end

   // Busy length counter and read-after-convert busy ceiling for checking
   logic [`BUSY_LEN_W-1:0] busy_len;
   logic [`BUSY_LEN_W-1:0] busy_max_rac;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         busy_len <= '0;
      else if (!ctrl_reg.busy)
         busy_len <= '0;
      else if (busy_len != '1)
         busy_len <= busy_len + `BUSY_LEN_W'(1);
   end

   // Read-after-convert busy ceiling per divider
   always_comb
   begin
      case (serial_clock_divider)
         2'h0:    busy_max_rac = `BUSY_LEN_W'(`FLOOR_CYC(`DIV0_BUSY_NS));
         2'h1:    busy_max_rac = `BUSY_LEN_W'(`FLOOR_CYC(`DIV1_BUSY_NS));
         2'h2:    busy_max_rac = `BUSY_LEN_W'(`FLOOR_CYC(`DIV2_BUSY_NS));
         default: busy_max_rac = `BUSY_LEN_W'(`FLOOR_CYC(`DIV3_BUSY_NS));
      endcase
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Conversion start, busy, bus release and serial clock timing checks
   a_busy_rise_start: assert property (
      strobe_fall && !busy && ctrl_reg.ser == SER_IDLE |=> busy && ctrl_reg.cnt == 1)
      else $error("busy did not rise after convert strobe");

   a_busy_width_max: assert property (
      mode != MODE_MASTER_RAC |-> busy_len <= BUSY_MAX_CYC)
      else $error("busy high too long");

   a_busy_after_eoc: assert property (
      $fell(busy) && mode != MODE_MASTER_RAC |-> $past(ctrl_reg.cnt) == BUSY_END_AT)
      else $error("busy fell at wrong point after conversion end");

   a_data_valid_time: assert property (
      ctrl_reg.cnt == CONV_AT |=> data_out == $past(conv_result_in))
      else $error("parallel result not captured at conversion end");

   a_data_before_busy: assert property (
      $fell(busy) && mode == MODE_PARALLEL |-> $stable(data_out) && $past(busy, 2))
      else $error("result changed as busy fell");

   a_bus_drive_data: assert property (
      mode == MODE_PARALLEL && !cs_n && !rd_n |-> data_oe && data_out == ctrl_reg.result)
      else $error("parallel bus not driven with result");

   a_bus_release: assert property (
      cs_n || rd_n || mode != MODE_PARALLEL |-> !data_oe)
      else $error("parallel bus driven without a request");

   a_serial_release: assert property (
      cs_n |-> !serial_pins.frame_oe && !serial_pins.clk_oe && !serial_pins.data_oe)
      else $error("serial pins driven while deselected");

   a_serial_drive: assert property (
      !cs_n && master |-> serial_pins.frame_oe && serial_pins.clk_oe && serial_pins.data_oe)
      else $error("serial pins not driven while selected");

   a_rdc_frame_time: assert property (
      mode == MODE_MASTER_RDC && ctrl_reg.cnt == RDC_SYNC_AT && ctrl_reg.ser == SER_IDLE
      |=> ctrl_reg.frame && busy)
      else $error("read-during-convert frame late");

   a_rdc_clock_period: assert property (
      mode == MODE_MASTER_RDC && $rose(sclk) |=> $fell(sclk))
      else $error("read-during-convert clock not at fastest period");

   a_rac_frame_time: assert property (
      mode == MODE_MASTER_RAC && ctrl_reg.cnt == RAC_SYNC_AT && ctrl_reg.ser == SER_IDLE
      |=> ctrl_reg.frame ##0 $past(ctrl_reg.cnt) > CONV_AT)
      else $error("read-after-convert frame at wrong time");

   a_rac_busy_release: assert property (
      mode == MODE_MASTER_RAC && $fell(ctrl_reg.frame) |-> busy ##1 !busy)
      else $error("busy not released one cycle after frame");

   a_clock_high_div3: assert property (
      mode == MODE_MASTER_RAC && serial_clock_divider == 2'h3 && $rose(sclk)
      |-> sclk [*3] ##1 !sclk)
      else $error("serial clock high phase wrong for divider 3");

   a_clock_period_div1: assert property (
      mode == MODE_MASTER_RAC && serial_clock_divider == 2'h1 && $rose(sclk)
      && ctrl_reg.bit_cnt != LAST_BIT
      |-> ##1 !sclk ##1 sclk)
      else $error("serial clock period wrong for divider 1");

   a_first_edge_lead: assert property (
      $rose(ctrl_reg.frame) |-> !sclk [*2])
      else $error("serial clock edge too soon after frame");

   a_rac_busy_max: assert property (
      mode == MODE_MASTER_RAC && serial_clock_divider != 2'h0 |-> busy_len <= busy_max_rac)
      else $error("read-after-convert busy too long");

   a_tail_gap_div3: assert property (
      $fell(ctrl_reg.frame) && serial_clock_divider == 2'h3 |-> !sclk && !$past(sclk, 3))
      else $error("frame dropped too soon after last clock edge");

   // Main scenarios
   c_parallel_conv: cover property (
      mode == MODE_PARALLEL && $fell(busy) ##1 !cs_n && !rd_n);
   c_rdc_transfer: cover property (
      mode == MODE_MASTER_RDC && $fell(ctrl_reg.frame));
   c_rac_div3: cover property (
      mode == MODE_MASTER_RAC && serial_clock_divider == 2'h3 && $fell(busy));
   c_slave_shift: cover property (
      mode == MODE_SLAVE && !cs_n && $rose(serial_data_clock_in));
   c_rac_first_rise: cover property (
      mode == MODE_MASTER_RAC && sclk_rise_next && ctrl_reg.bit_cnt == '0);

endmodule : adc_conversion_readout_timing

// >>> verification/host_reader.sv
// Host-side reader model: samples master serial frames, clocks slave reads
`timescale 1ns/1ps
module host_reader
   import adc_conv_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire serial_pins_type pins,
   input  wire logic            slave_go,
   output logic                 host_clk,
   output logic [17:0]          word,
   output logic [17:0]          sword,
   output int                   nbits,
   output int                   sbits,
   output int                   per,
   output int                   high,
   output int                   lead,
   output int                   tail
);
   int   cyc;
   int   t_frm;
   int   t_rise;
   int   t_edge;
   int   ph;
   logic clk_q;
   logic frm_q;

   initial host_clk = 1'h0;

   // Master read: take data on each rising serial clock inside the frame
   always @(posedge mclk)
   begin
      cyc   <= cyc + 1;
      clk_q <= pins.clk;
      frm_q <= pins.frame;
      if (!rst_n)
      begin
         clk_q <= 1'h0;
         frm_q <= 1'h0;
      end
      else if (pins.frame && !frm_q)
      begin
         t_frm <= cyc;
         nbits <= 0;
      end
      else if (pins.frame && pins.clk && !clk_q && pins.data_oe)
      begin
         lead   <= (nbits == 0) ? cyc - t_frm : lead;
         per    <= cyc - t_rise;
         t_rise <= cyc;
         word   <= {word[16:0], pins.data};
         nbits  <= nbits + 1;
      end
      else if (!pins.clk && clk_q)
      begin
         high   <= cyc - t_rise;
         t_edge <= cyc;
      end
      else if (!pins.frame && frm_q)
         tail <= cyc - t_edge;
   end

   // Slave read: clock toggles every two cycles, bit taken before each rise
   always @(negedge mclk)
   begin
      ph <= ph + 1;
      if (!slave_go)
      begin
         ph       <= 0;
         sbits    <= 0;
         host_clk <= 1'h0;
      end
      else if (ph[1:0] == 2'h0 && sbits < 18)
      begin
         host_clk <= 1'h1;
         sword    <= {sword[16:0], pins.data};
         sbits    <= sbits + 1;
      end
      else if (ph[1:0] == 2'h2)
         host_clk <= 1'h0;
   end
endmodule : host_reader

// >>> verification/adc_conversion_readout_timing_test.sv
// Self-checking bench for conversion sequencing and result readout
`timescale 1ns/1ps
module adc_conversion_readout_timing_test
   import adc_conv_pkg::*;
   ;
   logic             mclk = 1'h0;
   logic             rst_n, convert_start_n, cs_n, rd_n, slave_go, host_clk, busy, data_oe;
   logic [1:0]       div;
   logic [17:0]      result_in, data_out, word, sword, exp_res, prev;
   readout_mode_type mode;
   serial_pins_type  pins;
   int               nbits, sbits, per, high, lead, tail;
   int               seed, bad_count, n_compared, cycles;
   int               lim [5][4] = '{'{30, 60, 120, 240}, '{45, 90, 180, 360},
                        '{15, 30, 60, 120}, '{5, 7, 35, 90}, '{2550, 3400, 5000, 8200}};

   adc_conversion_readout_timing dut_u (
      .mclk                 (mclk),
      .rst_n                (rst_n),
      .convert_start_n      (convert_start_n),
      .mode                 (mode),
      .serial_clock_divider (div),
      .cs_n                 (cs_n),
      .rd_n                 (rd_n),
      .serial_data_clock_in (host_clk),
      .conv_result_in       (result_in),
      .busy                 (busy),
      .data_out             (data_out),
      .data_oe              (data_oe),
      .serial_pins          (pins)
   );

   host_reader host_u (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .pins     (pins),
      .slave_go (slave_go),
      .host_clk (host_clk),
      .word     (word),
      .sword    (sword),
      .nbits    (nbits),
      .sbits    (sbits),
      .per      (per),
      .high     (high),
      .lead     (lead),
      .tail     (tail)
   );

   // 25 MHz clock
   always #20 mclk = ~mclk;

   // Hang guard
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 10000)
      begin
         bad_count++;
         stop_test();
      end
   end

   // Window of one clock around a typical delay
   function automatic logic near(input int ns, input int typ);
      return (ns >= typ - 40) && (ns <= typ + 40);
   endfunction : near

   task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
      n_compared++;
      if (seen !== exp_v)
      begin
         bad_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp_v);
      end
   endtask : check

   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   // One conversion in mode m, optionally with an ignored strobe while busy
   task automatic conv(input readout_mode_type m, input logic [1:0] d, input logic dbl);
      int k = 1, kf = 0, kff = 0, kb = 0, kd = 0;
      prev = exp_res;
      exp_res = 18'($random(seed));
      mode = m;
      div = d;
      result_in = exp_res;
      convert_start_n = 1'h0; // Only while busy is low
      @(negedge mclk);
      check(busy, 1'h1);
      while ((busy || pins.frame) && k < 400)
      begin
         if (k == 2 || (dbl && k == 12))
            convert_start_n = 1'h1;
         if (dbl && k == 10)
            convert_start_n = 1'h0;
         kb = busy ? k : kb;
         kd = (kd == 0 && data_out === exp_res) ? k : kd;
         kf = (kf == 0 && pins.frame) ? k : kf;
         kff = pins.frame ? k + 1 : kff;
         @(negedge mclk);
         k++;
      end
      if (m != MODE_MASTER_RAC)
         check(kb * 40 <= 1680, 1'h1);
      if (m == MODE_PARALLEL)
      begin
         check(kd * 40 <= 1650, 1'h1);
         check(kd != 0 && kd <= kb, 1'h1);
      end
      if (m == MODE_MASTER_RDC)
      begin
         check(near(kf * 40, 530), 1'h1);
         check(word, prev);
      end
      if (m == MODE_MASTER_RAC)
      begin
         check(near(kf * 40, 1500), 1'h1);
         check(word, exp_res);
         check(kb, kff);
         check(high * 40 >= lim[2][d], 1'h1);
         check(lead * 40 >= (d == 2'h0 ? 3 : 20), 1'h1);
         check(tail * 40 >= lim[3][d], 1'h1);
         if (d != 2'h0)
         begin
            check(per * 40 >= lim[0][d] && per * 40 <= lim[1][d], 1'h1);
            check(kb * 40 <= lim[4][d], 1'h1);
         end
      end
      if (m == MODE_SLAVE)
      begin
         slave_go = 1'h1;
         for (k = 0; k < 200 && sbits < 18; k++)
            @(negedge mclk);
         check(sword, exp_res);
         slave_go = 1'h0;
      end
      // Bus request, then chip select released
      rd_n = 1'h0;
      #1;
      check(data_oe, m == MODE_PARALLEL);
      if (m == MODE_PARALLEL)
         check(data_out, exp_res);
      check({pins.frame_oe, pins.clk_oe}, {2{m == MODE_MASTER_RDC || m == MODE_MASTER_RAC}});
      cs_n = 1'h1;
      #1;
      check({data_oe, pins.frame_oe, pins.clk_oe, pins.data_oe}, 4'h0);
      cs_n = 1'h0;
      rd_n = 1'h1;
      repeat (4) @(negedge mclk);
   endtask : conv

   // Main sequence: fixed corner cases, then random conversions
   initial
   begin
      seed = 78;
      rst_n = 1'h0;
      convert_start_n = 1'h1;
      cs_n = 1'h0;
      rd_n = 1'h1;
      slave_go = 1'h0;
      mode = MODE_PARALLEL;
      div = 2'h0;
      result_in = 18'h0;
      exp_res = 18'h0;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'h1;
      check(busy, 1'h0);
      check(data_out, 18'h0);
      repeat (2) @(negedge mclk);
      conv(MODE_PARALLEL, 2'h0, 1'h1);
      conv(MODE_MASTER_RDC, 2'h0, 1'h0);
      for (int i = 0; i < 4; i++)
         conv(MODE_MASTER_RAC, 2'(i), 1'h0);
      for (int i = 0; i < 6; i++)
         conv(readout_mode_type'(2'($unsigned($random(seed)) % 3)), 2'($random(seed)),
              1'($random(seed)));
      conv(MODE_SLAVE, 2'h0, 1'h0);
      stop_test();
   end
endmodule : adc_conversion_readout_timing_test
